// >>> tsl_trip_limits.sv
// Contract
// - Temperature is signed, eighth degree steps
// - Lowest temperature word bit reads zero
// - Bit eleven weighs 128 degrees, halving downward
// - Top three bits are live trip status
// - Status bits never disturb temperature field
// - Limit reserved bits read zero, ignore writes
// - Limits hold signed quarter degree value
// - Upper limit is alarm window top
// - Lower limit is alarm window bottom
// - Critical limit decides critical trip
// - Compares use limits as soon as written
// - Critical flag: set at limit, hysteresis clear
// - Below flag: hysteresis set, clear at limit
module tsl_trip_limits
  import tsl_pkg::*;
(
  // System clock and reset
  input  wire logic       CLK,
  input  wire logic       RSTN,
  // Converter link, on its own clock
  input  wire logic       LINK_CLK,
  input  wire logic       LINK_VALID,
  input  wire tsl_temp_t  LINK_TEMP,
  // Hysteresis from configuration, eighth degree units
  input  wire logic [10:0] HYST,
  // Register port
  input  wire tsl_req_s   REQ,
  output logic [15:0]     RD_DATA,
  output logic            RD_VALID,
  // Trip status to the alert logic
  output tsl_flags_s      TRIP_FLAGS
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Limit field to eighth degree scale, sign extended to 14 bits
  function automatic logic signed [13:0] lim_to_eighths(input logic [15:0] lim);
    lim_to_eighths = {{2{lim[TSL_LIM_MSB]}}, lim[TSL_LIM_MSB:TSL_LIM_LSB], 1'b0};
  endfunction

  // Temperature sign extended to 14 bits
  function automatic logic signed [13:0] temp_ext(input tsl_temp_t t);
    temp_ext = {{2{t[TSL_TEMP_W-1]}}, t};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: hold sample, flag it with a toggle

  tsl_temp_t link_word_q;
  logic      link_tgl_q;

  // Word only changes with a toggle, so it is stable when sampled.
  // Limitation: samples closer than two link cycles may be lost.
  // Word only changes with a toggle, so it is stable when sampled
  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      link_word_q <= '0;
      link_tgl_q  <= 1'b0;
    end else if (LINK_VALID) begin
      link_word_q <= LINK_TEMP;
      link_tgl_q  <= ~link_tgl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into CLK domain

  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  wire  new_sample = tgl_s2_q ^ tgl_s3_q;

  // A toggle rather than a pulse crosses, so a stopped link clock
  // cannot leave a half-seen strobe behind. Only the second and edge
  // stages feed logic; the first may be metastable.
  // Two-stage synchroniser plus edge stage
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      tgl_s1_q <= link_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  tsl_temp_t temp_q;

  // Capture the settled sample word
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      temp_q <= '0;
    end else if (new_sample) begin
      temp_q <= link_word_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit registers

  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [15:0] crit_q;

  wire         wr_en    = REQ.valid & REQ.write;
  wire [15:0]  wr_field = REQ.wdata & TSL_LIM_MASK;
  wire         wr_upper = wr_en && (REQ.addr == TSL_IDX_UPPER);
  wire         wr_lower = wr_en && (REQ.addr == TSL_IDX_LOWER);
  wire         wr_crit  = wr_en && (REQ.addr == TSL_IDX_CRIT);

  // Reserved bits never stored; temperature word is not writable
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      upper_q <= TSL_LIM_RESET;
      lower_q <= TSL_LIM_RESET;
      crit_q  <= TSL_LIM_RESET;
    end else begin
      if (wr_upper) upper_q <= wr_field;
      if (wr_lower) lower_q <= wr_field;
      if (wr_crit)  crit_q  <= wr_field;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip compares

  wire signed [13:0] t_s    = temp_ext(temp_q);
  wire signed [13:0] up_s   = lim_to_eighths(upper_q);
  wire signed [13:0] lo_s   = lim_to_eighths(lower_q);
  wire signed [13:0] cr_s   = lim_to_eighths(crit_q);
  wire signed [13:0] hyst_s = {3'b000, HYST};

  // Fourteen bits leave room for the lowest limit minus the largest
  // hysteresis, so the subtractions below cannot wrap.
  // Thresholds with hysteresis applied
  wire signed [13:0] up_clr_s = up_s - hyst_s;
  wire signed [13:0] lo_set_s = lo_s - hyst_s;
  wire signed [13:0] cr_clr_s = cr_s - hyst_s;

  wire crit_set  = (t_s >= cr_s);
  wire crit_clr  = (t_s < cr_clr_s);
  wire above_set = (t_s > up_s);
  wire above_clr = (t_s <= up_clr_s);
  wire below_set = (t_s < lo_set_s);
  wire below_clr = (t_s >= lo_s);

  tsl_flags_s flags_q;
  tsl_flags_s flags_d;

  // Set dominates so a band left by a shrunk hysteresis cannot chatter
  always_comb begin
    flags_d       = flags_q;
    flags_d.crit  = crit_set  | (flags_q.crit  & ~crit_clr);
    flags_d.above = above_set | (flags_q.above & ~above_clr);
    flags_d.below = below_set | (flags_q.below & ~below_clr);
  end

  // Re-evaluated every cycle from the live limits
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign TRIP_FLAGS = flags_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Flags sit above the field, never mixed into it
  wire [15:0] temp_word = {flags_q, temp_q, 1'b0};
  wire        rd_en     = REQ.valid & ~REQ.write;
  logic [15:0] rd_mux;

  // Address decode, unmapped reads return zero
  always_comb begin
    if (REQ.addr == TSL_IDX_TEMP) begin
      rd_mux = temp_word;
    end else if (REQ.addr == TSL_IDX_UPPER) begin
      rd_mux = upper_q;
    end else if (REQ.addr == TSL_IDX_LOWER) begin
      rd_mux = lower_q;
    end else if (REQ.addr == TSL_IDX_CRIT) begin
      rd_mux = crit_q;
    end else begin
      rd_mux = TSL_RD_ZERO;
    end
  end

  logic [15:0] rd_data_q;
  logic        rd_valid_q;

  // Read data held until the next read
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_data_q  <= TSL_RD_ZERO;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
      if (rd_en) rd_data_q <= rd_mux;
    end
  end

  assign RD_DATA  = rd_data_q;
  assign RD_VALID = rd_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence temp_read_s;
    rd_en && (REQ.addr == TSL_IDX_TEMP);
  endsequence

  sequence sample_arrive_s;
    $changed(tgl_s2_q) ##1 1'b1;
  endsequence

  lsb_zero_a: assert property (temp_read_s |=> RD_VALID && !RD_DATA[0])
    else $error("temperature word bit 0 not zero");

  temp_read_a: assert property (temp_read_s |=> RD_DATA == {$past(flags_q), $past(temp_q), 1'b0})
    else $error("temperature word mismatch");

  sample_take_a: assert property (sample_arrive_s |-> temp_q == link_word_q)
    else $error("sample not captured after crossing");

  lim_reserved_a: assert property ((upper_q & ~TSL_LIM_MASK) == 16'h0000 &&
                                   (crit_q & ~TSL_LIM_MASK) == 16'h0000)
    else $error("limit reserved bit set");

  lim_write_a: assert property (wr_lower |=> lower_q == ($past(REQ.wdata) & TSL_LIM_MASK))
    else $error("lower limit write lost");

  crit_set_a: assert property (t_s >= cr_s |=> TRIP_FLAGS.crit)
    else $error("critical flag not set");

  crit_clear_a: assert property (t_s < cr_clr_s && !(t_s >= cr_s) |=> !TRIP_FLAGS.crit)
    else $error("critical flag not cleared");

  above_set_a: assert property (t_s > up_s |=> TRIP_FLAGS.above)
    else $error("above flag not set");

  below_clear_a: assert property (t_s >= lo_s && !(t_s < lo_set_s) |=> !TRIP_FLAGS.below)
    else $error("below flag not cleared");

  below_set_a: assert property (t_s < lo_set_s |=> TRIP_FLAGS.below)
    else $error("below flag not set");

  live_limit_a: assert property (wr_crit ##1 (t_s >= cr_s) |=> TRIP_FLAGS.crit)
    else $error("new critical limit not used");

  ////////////////////////////////////////////////////////////////////////////
  // Hysteresis band checks

  // Flag already up and its clear threshold not yet crossed
  sequence crit_band_s;
    TRIP_FLAGS.crit && !crit_clr;
  endsequence

  sequence above_band_s;
    TRIP_FLAGS.above && !above_clr;
  endsequence

  sequence below_band_s;
    TRIP_FLAGS.below && !below_clr;
  endsequence

  // Flags must not drop while inside their band
  crit_hold_a: assert property (crit_band_s |=> TRIP_FLAGS.crit)
    else $error("critical flag dropped inside band");

  above_hold_a: assert property (above_band_s |=> TRIP_FLAGS.above)
    else $error("above flag dropped inside band");

  below_hold_a: assert property (below_band_s |=> TRIP_FLAGS.below)
    else $error("below flag dropped inside band");

  above_clear_a: assert property (above_clr && !above_set |=> !TRIP_FLAGS.above)
    else $error("above flag not cleared");

  // Flags must not rise without their set condition
  crit_quiet_a: assert property (!TRIP_FLAGS.crit && !crit_set |=> !TRIP_FLAGS.crit)
    else $error("critical flag rose without cause");

  above_quiet_a: assert property (!TRIP_FLAGS.above && !above_set |=> !TRIP_FLAGS.above)
    else $error("above flag rose without cause");

  below_quiet_a: assert property (!TRIP_FLAGS.below && !below_set |=> !TRIP_FLAGS.below)
    else $error("below flag rose without cause");

  ////////////////////////////////////////////////////////////////////////////
  // Limit register checks

  sequence upper_read_s;
    rd_en && (REQ.addr == TSL_IDX_UPPER);
  endsequence

  sequence lower_read_s;
    rd_en && (REQ.addr == TSL_IDX_LOWER);
  endsequence

  sequence crit_read_s;
    rd_en && (REQ.addr == TSL_IDX_CRIT);
  endsequence

  // Read-back shows exactly the stored field
  upper_read_a: assert property (upper_read_s |=> RD_DATA == $past(upper_q))
    else $error("upper limit read mismatch");

  lower_read_a: assert property (lower_read_s |=> RD_DATA == $past(lower_q))
    else $error("lower limit read mismatch");

  crit_read_a: assert property (crit_read_s |=> RD_DATA == $past(crit_q))
    else $error("critical limit read mismatch");

  upper_write_a: assert property (wr_upper |=> upper_q == ($past(REQ.wdata) & TSL_LIM_MASK))
    else $error("upper limit write lost");

  crit_write_a: assert property (wr_crit |=> crit_q == ($past(REQ.wdata) & TSL_LIM_MASK))
    else $error("critical limit write lost");

  lower_reserved_a: assert property ((lower_q & ~TSL_LIM_MASK) == 16'h0000)
    else $error("lower limit reserved bit set");

  ////////////////////////////////////////////////////////////////////////////
  // Sample path checks

  // Temperature only moves when a crossed sample arrives
  temp_hold_a: assert property (!new_sample |=> temp_q == $past(temp_q))
    else $error("temperature changed without sample");

  // Link side keeps the word it was handed
  link_take_a: assert property (@(posedge LINK_CLK) LINK_VALID |=> link_word_q == $past(LINK_TEMP))
    else $error("link sample not held");

endmodule // tsl_trip_limits

// >>> tsl_pkg.sv
package tsl_pkg;

  // Register indices on the internal register port
  localparam logic [7:0] TSL_IDX_UPPER = 8'h02;
  localparam logic [7:0] TSL_IDX_LOWER = 8'h03;
  localparam logic [7:0] TSL_IDX_CRIT  = 8'h04;
  localparam logic [7:0] TSL_IDX_TEMP  = 8'h05;

  // Temperature word layout
  localparam int TSL_TEMP_LSB    = 1;
  localparam int TSL_TEMP_MSB    = 12;
  localparam int TSL_FLAG_BELOW  = 13;
  localparam int TSL_FLAG_ABOVE  = 14;
  localparam int TSL_FLAG_CRIT   = 15;

  // Limit layout: sign at 12, quarter degree at bit 2
  localparam int TSL_LIM_LSB     = 2;
  localparam int TSL_LIM_MSB     = 12;
  localparam logic [15:0] TSL_LIM_MASK  = 16'h1FFC;
  localparam logic [15:0] TSL_LIM_RESET = 16'h0000;
  localparam logic [15:0] TSL_RD_ZERO   = 16'h0000;

  // Widths
  localparam int TSL_TEMP_W = 12;
  localparam int TSL_HYST_W = 11;

  typedef logic [TSL_TEMP_W-1:0] tsl_temp_t;

  // One register port request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } tsl_req_s;

  // Trip status flags, msb first as in the word
  typedef struct packed {
    logic crit;
    logic above;
    logic below;
  } tsl_flags_s;

endpackage : tsl_pkg

// >>> tsl_link_model.sv
module tsl_link_model
  import tsl_pkg::*;
(
  // Converter link toward the block
  output logic      LINK_CLK,
  output logic      LINK_VALID,
  output tsl_temp_t LINK_TEMP
);
  timeunit 1ns;
  timeprecision 1ps;

  // Link idles low; clock stands still between samples
  initial begin
    LINK_CLK   = 1'b0;
    LINK_VALID = 1'b0;
    LINK_TEMP  = 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////
  // One sample as a frame, then two idle link cycles for the spacing
  task automatic send(input tsl_temp_t v);
    #7 LINK_TEMP = v;  // Odd offset keeps the link out of step with CLK
    LINK_VALID = 1'b1;
    #16 LINK_CLK = 1'b1;
    #16 LINK_CLK = 1'b0;
    LINK_VALID = 1'b0;
    LINK_TEMP  = ~v;  // Stale data must not look valid
    repeat (2) begin
      #16 LINK_CLK = 1'b1;
      #16 LINK_CLK = 1'b0;
    end
  endtask
endmodule // tsl_link_model

// >>> tsl_trip_limits_tb_top.sv
module tsl_trip_limits_tb_top
  import tsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    tsl_temp_t   t;
    logic [15:0] w;
  } tsl_row_s;

  logic        CLK = 1'b0;
  logic        RSTN = 1'b0;
  tsl_req_s    REQ = '0;
  logic [10:0] HYST = 11'h000;
  logic        LINK_CLK;
  logic        LINK_VALID;
  tsl_temp_t   LINK_TEMP;
  logic [15:0] RD_DATA;
  logic        RD_VALID;
  tsl_flags_s  TRIP_FLAGS;
  logic [15:0] d;
  int          mismatches = 0;
  int          compares = 0;
  int          cycles = 0;

  // Window 1 C to 85 C, critical 95 C; word = temp*2 plus flags
  localparam tsl_row_s ROWS [10] = '{
    '{12'h3E8, 16'hC7D0}, '{12'h0C8, 16'h0190}, '{12'h008, 16'h0010}, '{12'h001, 16'h2002},
    '{12'h000, 16'h2000}, '{12'hFFF, 16'h3FFE}, '{12'hE48, 16'h3C90}, '{12'h2A8, 16'h0550},
    '{12'h2A9, 16'h4552}, '{12'h2F8, 16'hC5F0}};
  // With 1 C of hysteresis: temperature and expected flags
  localparam tsl_row_s HYS [7] = '{
    '{12'h2F8, 16'h0006}, '{12'h2F4, 16'h0006}, '{12'h2EF, 16'h0002}, '{12'h004, 16'h0000},
    '{12'hFFF, 16'h0001}, '{12'h004, 16'h0001}, '{12'h008, 16'h0000}};

  tsl_trip_limits uut (
    .CLK        (CLK),
    .RSTN       (RSTN),
    .LINK_CLK   (LINK_CLK),
    .LINK_VALID (LINK_VALID),
    .LINK_TEMP  (LINK_TEMP),
    .HYST       (HYST),
    .REQ        (REQ),
    .RD_DATA    (RD_DATA),
    .RD_VALID   (RD_VALID),
    .TRIP_FLAGS (TRIP_FLAGS)
  );

  tsl_link_model link (
    .LINK_CLK   (LINK_CLK),
    .LINK_VALID (LINK_VALID),
    .LINK_TEMP  (LINK_TEMP)
  );

  ////////////////////////////////////////////////////////////////////////
  // 250 MHz system clock and hang guard
  always #2 CLK = ~CLK;

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic summarize;
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Requests go up at a falling edge and are taken at the next rising one
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    REQ = '{1'b1, 1'b1, a, v};
    @(negedge CLK);
    REQ.valid = 1'b0;
    @(negedge CLK);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    REQ = '{1'b1, 1'b0, a, 16'h0000};
    @(negedge CLK);
    chk("rd_valid", {15'h0000, RD_VALID}, 16'h0001);
    v = RD_DATA;
    REQ.valid = 1'b0;
    @(negedge CLK);
  endtask

  task automatic flg(input logic [2:0] e);
    chk("trip_flags", {13'h0000, TRIP_FLAGS}, {13'h0000, e});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(negedge CLK);
    RSTN = 1'b1;
    for (int i = 2; i < 5; i++) begin
      rd(8'(i), d);
      chk("limit_reset", d, 16'h0000);
    end
    wr(TSL_IDX_CRIT, 16'hFFFF);
    rd(TSL_IDX_CRIT, d);
    chk("crit_mask", d, 16'h1FFC);
    // Limits settle before the first sample; the zero reset temperature holds the below flag up until then
    wr(TSL_IDX_UPPER, 16'h0550);
    wr(TSL_IDX_LOWER, 16'h0010);
    wr(TSL_IDX_CRIT, 16'h05F0);
    rd(TSL_IDX_UPPER, d);
    chk("upper_limit", d, 16'h0550);
    foreach (ROWS[i]) begin
      link.send(ROWS[i].t);
      @(negedge CLK);  // Back onto the stimulus edge after the link frame
      rd(TSL_IDX_TEMP, d);
      chk("temp_word", d, ROWS[i].w);
      flg(ROWS[i].w[15:13]);
    end
    // Read-only temperature and unmapped place
    wr(TSL_IDX_TEMP, 16'h0000);
    rd(TSL_IDX_TEMP, d);
    chk("temp_ro", d, 16'hC5F0);
    rd(8'h77, d);
    chk("unmapped", d, 16'h0000);
    // New limit acts at once
    wr(TSL_IDX_CRIT, 16'h0600);
    flg(3'b010);
    wr(TSL_IDX_CRIT, 16'h05F0);
    HYST = 11'h008;
    foreach (HYS[i]) begin
      link.send(HYS[i].t);
      @(negedge CLK);
      flg(HYS[i].w[2:0]);
    end
    summarize();
  end
endmodule // tsl_trip_limits_tb_top
